// File: src/bld_pkg.sv
// ==========================================================================
// shared constants for the broadcast label field decoder
// ==========================================================================
package bld_pkg;

	localparam int          BYTE_W    = 8;   // one received packet byte
	localparam int          NIB_W     = 4;   // one message nibble or digit
	localparam int          PKT_BYTES = 26;  // bytes 0..25 of a service packet
	localparam int          IDX_W     = 5;   // width of a byte index
	localparam int          BIT_IDX_W = 3;   // width of a bit-in-byte count

	// ======================================================================
	// format 1 (date and time) byte positions
	// ======================================================================
	localparam logic [4:0]  F1_OFFSET  = 5'h0F; // local time offset code
	localparam logic [4:0]  F1_MJD_HI  = 5'h10; // ten-thousands digit, low nibble
	localparam logic [4:0]  F1_MJD_MID = 5'h11; // hundreds low, thousands high
	localparam logic [4:0]  F1_MJD_LO  = 5'h12; // units low, tens high
	localparam logic [4:0]  F1_HOUR    = 5'h13; // hours units / tens
	localparam logic [4:0]  F1_MIN     = 5'h14; // minutes units / tens
	localparam logic [4:0]  F1_SEC     = 5'h15; // seconds units / tens
	localparam logic [4:0]  F1_FIRST   = F1_OFFSET;
	localparam logic [4:0]  F1_LAST    = F1_SEC;

	// ======================================================================
	// format 2 (programme label) byte positions
	// ======================================================================
	localparam logic [4:0]  F2_LABEL   = 5'h0D; // channel id and update flag
	localparam logic [4:0]  F2_SOUND   = 5'h0E; // analogue sound status
	localparam logic [4:0]  F2_NET_A   = 5'h0F; // network id bits 1..4
	localparam logic [4:0]  F2_MIX_A   = 5'h10; // network 9..10, label 1..2
	localparam logic [4:0]  F2_PIL_B   = 5'h11; // label bits 3..6
	localparam logic [4:0]  F2_PIL_C   = 5'h12; // label bits 7..10
	localparam logic [4:0]  F2_PIL_D   = 5'h13; // label bits 11..14
	localparam logic [4:0]  F2_PIL_E   = 5'h14; // label bits 15..18
	localparam logic [4:0]  F2_MIX_B   = 5'h15; // label 19..20, network 5..6
	localparam logic [4:0]  F2_NET_B   = 5'h16; // network 7..8 and 11..12
	localparam logic [4:0]  F2_NET_C   = 5'h17; // network 13..16
	localparam logic [4:0]  F2_PTY_LO  = 5'h18; // programme type 1..4
	localparam logic [4:0]  F2_PTY_HI  = 5'h19; // programme type 5..8
	localparam logic [4:0]  F2_FIRST   = F2_LABEL;
	localparam logic [4:0]  F2_LAST    = F2_PTY_HI;

	localparam logic [3:0]  DIGIT_BIAS = 4'h1; // added to each digit on air
	localparam int          OFS_SIGN   = 6;    // sign bit of the offset code
	localparam int          OFS_MAG_W  = 6;    // magnitude bits 0..5

	// four message bits of a protected byte sit at odd bit positions
	function automatic logic [NIB_W-1:0] msg_nibble(input logic [BYTE_W-1:0] b);
		msg_nibble = {b[7], b[5], b[3], b[1]};
	endfunction : msg_nibble

	// remove the transmitter's plus-one from a decimal digit
	function automatic logic [NIB_W-1:0] digit_fix(input logic [NIB_W-1:0] d);
		digit_fix = d - DIGIT_BIAS;
	endfunction : digit_fix

endpackage : bld_pkg

// File: src/bld_link_if.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// byte read link between the label decoder and its reading host
// ==========================================================================
interface bld_link_if
	import bld_pkg::*;
(
	input wire logic clk_i // shared clock
);
	logic                  pkt_ready; // one-cycle pulse: a packet is stored
	logic                  pkt_fmt2;  // stored packet is format 2
	logic                  rd_req;    // host asks for one byte
	logic [IDX_W-1:0]      rd_addr;   // byte index asked for
	logic                  rd_ack;    // byte answer, one cycle
	logic [BYTE_W-1:0]     rd_data;   // byte as received

	modport device (
		output pkt_ready, pkt_fmt2, rd_ack, rd_data,
		input  rd_req, rd_addr
	);
	modport host (
		input  pkt_ready, pkt_fmt2, rd_ack, rd_data,
		output rd_req, rd_addr
	);
endinterface : bld_link_if
`default_nettype wire

// File: src/bld_device.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// decoder end: collects slicer bits into packet bytes, serves them unaltered
// ==========================================================================
module bld_device
	import bld_pkg::*;
(
	input  wire logic    clk_i,       // system clock
	input  wire logic    rst_n_i,     // synchronous reset, active low
	input  wire logic    rx_start_i,  // pulse: packet begins with next bit
	input  wire logic    rx_fmt2_i,   // packet being received is format 2
	input  wire logic    rx_bit_i,    // sliced data bit
	input  wire logic    rx_bit_en_i, // pulse: rx_bit_i is valid
	output logic         rx_busy_o,   // packet reception in progress
	bld_link_if.device   link         // read side toward the host
);

	logic [BYTE_W-1:0]    shift_q;
	logic [BIT_IDX_W-1:0] bit_cnt_q;
	logic [IDX_W-1:0]     byte_cnt_q;
	logic                 active_q;
	logic                 fmt2_q;
	logic                 ready_q;
	logic                 ack_q;
	logic [BYTE_W-1:0]    data_q;
	logic [BYTE_W-1:0]    mem [PKT_BYTES];
	logic [BYTE_W-1:0]    byte_d;
	logic                 byte_done;

	localparam logic [BIT_IDX_W-1:0] LAST_BIT  = 3'h7;
	localparam logic [IDX_W-1:0]     LAST_BYTE = 5'h19;

	// first bit on air lands in bit 0, so no reordering is ever needed
	assign byte_d    = {rx_bit_i, shift_q[BYTE_W-1:1]};
	// a start in the same cycle wins, so that bit must not close a byte
	assign byte_done = active_q && rx_bit_en_i && !rx_start_i && (bit_cnt_q == LAST_BIT);

	// ======================================================================
	// bit and byte framing
	// ======================================================================
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			shift_q    <= 8'h00;
			bit_cnt_q  <= 3'h0;
			byte_cnt_q <= 5'h00;
			active_q   <= 1'b0;
		end else if (rx_start_i) begin
			bit_cnt_q  <= 3'h0;
			byte_cnt_q <= 5'h00;
			active_q   <= 1'b1;
		end else if (active_q && rx_bit_en_i) begin
			shift_q   <= byte_d;
			bit_cnt_q <= bit_cnt_q + 3'h1;
			if (byte_done) begin
				byte_cnt_q <= byte_cnt_q + 5'h01;
				if (byte_cnt_q == LAST_BYTE) begin
					active_q <= 1'b0;
				end
			end
		end
	end

	// bytes stored by arrival index; fields stay where they were sent
	always_ff @(posedge clk_i) begin
		if (byte_done) begin
			mem[byte_cnt_q] <= byte_d;
		end
	end

	// ======================================================================
	// packet ready pulse and format tag
	// ======================================================================
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ready_q <= 1'b0;
			fmt2_q  <= 1'b0;
		end else begin
			ready_q <= byte_done && (byte_cnt_q == LAST_BYTE);
			if (rx_start_i) begin
				fmt2_q <= rx_fmt2_i;
			end
		end
	end

	// ======================================================================
	// read port: registered answer one cycle after the request
	// ======================================================================
	// a new packet overwrites the store; host must finish before it lands
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ack_q  <= 1'b0;
			data_q <= 8'h00;
		end else begin
			ack_q <= link.rd_req;
			if (link.rd_req) begin
				if (link.rd_addr <= LAST_BYTE) begin
					data_q <= mem[link.rd_addr];
				end else begin
					data_q <= 8'h00;
				end
			end
		end
	end

	assign link.pkt_ready = ready_q;
	assign link.pkt_fmt2  = fmt2_q;
	assign link.rd_ack    = ack_q;
	assign link.rd_data   = data_q;
	assign rx_busy_o      = active_q;

endmodule : bld_device
`default_nettype wire

// File: src/bld_host.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - decoder passes bytes unaltered, in order
// - host subtracts one from each date digit
// - first received bit is lowest weight
// - julian day digits in bytes 16 to 18
// - hours, minutes, seconds in bytes 19-21
// - byte 13: channel id, update flag
// - bytes 16-21 carry programme label fields
// - byte 14 low bits: sound status
// - network id spread over five bytes
// - label: day, month, hour, minute
// - programme type in bytes 24, 25
// ==========================================================================
// host end: reads a stored packet byte by byte and splits out the fields
// ==========================================================================
module bld_host
	import bld_pkg::*;
(
	input  wire logic    clk_i,                // system clock
	input  wire logic    rst_n_i,              // synchronous reset, active low
	bld_link_if.host     link,                 // read side toward the decoder
	output logic         busy_o,               // packet being fetched
	output logic         f1_valid_o,           // pulse: date/time fields new
	output logic         f2_valid_o,           // pulse: label fields new
	output logic [19:0]  julian_day_number_o,  // five decimal digits
	output logic [23:0]  unified_date_time_o,  // hh mm ss decimal digits
	output logic         offset_neg_o,         // local offset is negative
	output logic [5:0]   offset_mag_o,         // offset magnitude, quarter hours
	output logic [1:0]   label_channel_id_o,   // label channel identifier
	output logic         label_update_flag_o,  // label update flag
	output logic [1:0]   sound_status_o,       // analogue sound status
	output logic [15:0]  network_country_id_o, // network and country id
	output logic [19:0]  programme_label_o,    // whole label, bit 0 first
	output logic [4:0]   label_day_o,          // label day
	output logic [3:0]   label_month_o,        // label month
	output logic [4:0]   label_hour_o,         // label hour
	output logic [5:0]   label_minute_o,       // label minute
	output logic [7:0]   programme_type_o      // programme type
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_REQ,
		ST_WAIT,
		ST_DECODE
	} bld_host_state_type;

	bld_host_state_type  state_q;
	logic [IDX_W-1:0]    addr_q;
	logic [IDX_W-1:0]    last_q;
	logic                fmt2_q;
	logic [BYTE_W-1:0]   buf_q [PKT_BYTES];

	// message nibbles of the format 2 bytes
	logic [NIB_W-1:0]    n_label;
	logic [NIB_W-1:0]    n_sound;
	logic [NIB_W-1:0]    n_net_a;
	logic [NIB_W-1:0]    n_mix_a;
	logic [NIB_W-1:0]    n_pil_b;
	logic [NIB_W-1:0]    n_pil_c;
	logic [NIB_W-1:0]    n_pil_d;
	logic [NIB_W-1:0]    n_pil_e;
	logic [NIB_W-1:0]    n_mix_b;
	logic [NIB_W-1:0]    n_net_b;
	logic [NIB_W-1:0]    n_net_c;
	logic [NIB_W-1:0]    n_pty_lo;
	logic [NIB_W-1:0]    n_pty_hi;
	logic [19:0]         pil_d;

	// ======================================================================
	// fetch sequence
	// ======================================================================
	// a ready pulse while busy is ignored; the decoder's store is single,
	// so the whole fetch must end before its next packet arrives
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_q <= ST_IDLE;
			addr_q  <= 5'h00;
			last_q  <= 5'h00;
			fmt2_q  <= 1'b0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (link.pkt_ready) begin
						fmt2_q  <= link.pkt_fmt2;
						addr_q  <= link.pkt_fmt2 ? F2_FIRST : F1_FIRST;
						last_q  <= link.pkt_fmt2 ? F2_LAST : F1_LAST;
						state_q <= ST_REQ;
					end
				end
				ST_REQ: begin
					state_q <= ST_WAIT;
				end
				ST_WAIT: begin
					if (link.rd_ack) begin
						if (addr_q == last_q) begin
							state_q <= ST_DECODE;
						end else begin
							addr_q  <= addr_q + 5'h01;
							state_q <= ST_REQ;
						end
					end
				end
				ST_DECODE: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// each answered byte is kept at its own packet index
	always_ff @(posedge clk_i) begin
		if (state_q == ST_WAIT && link.rd_ack) begin
			buf_q[addr_q] <= link.rd_data;
		end
	end

	assign link.rd_req  = (state_q == ST_REQ);
	assign link.rd_addr = addr_q;
	assign busy_o       = (state_q != ST_IDLE);

	// ======================================================================
	// format 2 message nibbles
	// ======================================================================
	assign n_label  = msg_nibble(buf_q[F2_LABEL]);
	assign n_sound  = msg_nibble(buf_q[F2_SOUND]);
	assign n_net_a  = msg_nibble(buf_q[F2_NET_A]);
	assign n_mix_a  = msg_nibble(buf_q[F2_MIX_A]);
	assign n_pil_b  = msg_nibble(buf_q[F2_PIL_B]);
	assign n_pil_c  = msg_nibble(buf_q[F2_PIL_C]);
	assign n_pil_d  = msg_nibble(buf_q[F2_PIL_D]);
	assign n_pil_e  = msg_nibble(buf_q[F2_PIL_E]);
	assign n_mix_b  = msg_nibble(buf_q[F2_MIX_B]);
	assign n_net_b  = msg_nibble(buf_q[F2_NET_B]);
	assign n_net_c  = msg_nibble(buf_q[F2_NET_C]);
	assign n_pty_lo = msg_nibble(buf_q[F2_PTY_LO]);
	assign n_pty_hi = msg_nibble(buf_q[F2_PTY_HI]);

	// label bits 1..20 in arrival order, bit 1 at position 0
	assign pil_d = {n_mix_b[1:0], n_pil_e, n_pil_d, n_pil_c, n_pil_b, n_mix_a[3:2]};

	// ======================================================================
	// format 1 fields: date, time and offset
	// ======================================================================
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			julian_day_number_o <= 20'h00000;
			unified_date_time_o <= 24'h000000;
			offset_neg_o        <= 1'b0;
			offset_mag_o        <= 6'h00;
		end else if (state_q == ST_DECODE && !fmt2_q) begin
			julian_day_number_o <= {
				digit_fix(buf_q[F1_MJD_HI][3:0]),
				digit_fix(buf_q[F1_MJD_MID][7:4]),
				digit_fix(buf_q[F1_MJD_MID][3:0]),
				digit_fix(buf_q[F1_MJD_LO][7:4]),
				digit_fix(buf_q[F1_MJD_LO][3:0])
			};
			unified_date_time_o <= {
				digit_fix(buf_q[F1_HOUR][7:4]), digit_fix(buf_q[F1_HOUR][3:0]),
				digit_fix(buf_q[F1_MIN][7:4]), digit_fix(buf_q[F1_MIN][3:0]),
				digit_fix(buf_q[F1_SEC][7:4]), digit_fix(buf_q[F1_SEC][3:0])
			};
			offset_neg_o <= buf_q[F1_OFFSET][OFS_SIGN];
			offset_mag_o <= buf_q[F1_OFFSET][OFS_MAG_W-1:0];
		end
	end

	// ======================================================================
	// format 2 fields: label header, network id, label, type
	// ======================================================================
	// reserved message bits are read but never passed on
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			label_channel_id_o   <= 2'h0;
			label_update_flag_o  <= 1'b0;
			sound_status_o       <= 2'h0;
			network_country_id_o <= 16'h0000;
			programme_label_o    <= 20'h00000;
			programme_type_o     <= 8'h00;
		end else if (state_q == ST_DECODE && fmt2_q) begin
			label_channel_id_o   <= n_label[1:0];
			label_update_flag_o  <= n_label[2];
			sound_status_o       <= n_sound[1:0];
			network_country_id_o <= {n_net_c, n_net_b[3:2], n_mix_a[1:0],
				n_net_b[1:0], n_mix_b[3:2], n_net_a};
			programme_label_o    <= pil_d;
			programme_type_o     <= {n_pty_hi, n_pty_lo};
		end
	end

	// split of the label into its four parts, in transmission order
	assign label_day_o    = programme_label_o[4:0];
	assign label_month_o  = programme_label_o[8:5];
	assign label_hour_o   = programme_label_o[13:9];
	assign label_minute_o = programme_label_o[19:14];

	// ======================================================================
	// completion pulses, one cycle after the decode step
	// ======================================================================
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			f1_valid_o <= 1'b0;
			f2_valid_o <= 1'b0;
		end else begin
			f1_valid_o <= (state_q == ST_DECODE) && !fmt2_q;
			f2_valid_o <= (state_q == ST_DECODE) && fmt2_q;
		end
	end

endmodule : bld_host
`default_nettype wire

// File: test/bld_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// read link checks, decoder end against host end
// ==========================================================================
module bld_link_sva
	import bld_pkg::*;
(
	input wire logic              clk_i,     // shared clock
	input wire logic              rst_n_i,   // sync reset, active low
	input wire logic              pkt_ready, // packet stored pulse
	input wire logic              pkt_fmt2,  // stored packet format
	input wire logic              rd_req,    // byte request
	input wire logic [IDX_W-1:0]  rd_addr,   // byte index
	input wire logic              rd_ack,    // byte answer
	input wire logic [BYTE_W-1:0] rd_data    // byte value
);
	// one domain, so one clocking and one disable for all
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	// request, then answer with the link quiet in the answer cycle
	sequence s_req_ack;
		rd_req ##1 (rd_ack && !rd_req);
	endsequence
	sequence s_f2_end;
		rd_ack && pkt_fmt2 && (rd_addr == F2_LAST);
	endsequence

	property p_ack_follows; rd_req |-> s_req_ack; endproperty
	a_ack_follows: assert property (p_ack_follows)
		else $error("request not answered next cycle");
	property p_ack_cause; rd_ack |-> $past(rd_req); endproperty
	a_ack_cause: assert property (p_ack_cause)
		else $error("answer without request");
	property p_ready_pulse; pkt_ready |=> !pkt_ready; endproperty
	a_ready_pulse: assert property (p_ready_pulse)
		else $error("packet ready longer than one cycle");
	// a fetch opens on the first byte its format uses
	property p_first_addr;
		rd_req && !$past(rd_ack) |-> rd_addr == (pkt_fmt2 ? F2_FIRST : F1_FIRST);
	endproperty
	a_first_addr: assert property (p_first_addr)
		else $error("fetch starts at wrong byte");
	property p_addr_step; rd_req && $past(rd_ack) |-> rd_addr == $past(rd_addr) + 5'h01; endproperty
	a_addr_step: assert property (p_addr_step)
		else $error("bytes not read in order");
	// the answer byte must not drift while nothing is asked
	property p_data_hold; !$past(rd_req) |-> $stable(rd_data); endproperty
	a_data_hold: assert property (p_data_hold)
		else $error("read data changed without request");
	property p_f1_range; rd_ack && !pkt_fmt2 |-> rd_addr inside {[F1_FIRST:F1_LAST]}; endproperty
	a_f1_range: assert property (p_f1_range)
		else $error("format 1 byte out of range");
	property p_f2_range; rd_ack && pkt_fmt2 |-> rd_addr inside {[F2_FIRST:F2_LAST]}; endproperty
	a_f2_range: assert property (p_f2_range)
		else $error("format 2 byte out of range");
	property p_f2_end; s_f2_end |=> !rd_req [*2]; endproperty
	a_f2_end: assert property (p_f2_end)
		else $error("read past last type byte");
endmodule : bld_link_sva
`default_nettype wire

// File: test/tb_broadcast_label_field_decoder.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// both ends joined; slicer bits in, decoded fields checked
// ==========================================================================
module tb_broadcast_label_field_decoder
	import bld_pkg::*;
;
	logic        clk_i, rst_n_i, rx_start, rx_fmt2, rx_bit, rx_bit_en;
	logic        rx_busy, busy, f1_v, f2_v, ofs_neg, label_update_flag;
	logic [19:0] jdn, label;
	logic [23:0] unified_date_time;
	logic [5:0]  ofs_mag, minute;
	logic [1:0]  lci, snd;
	logic [15:0] net;
	logic [4:0]  day, hour;
	logic [3:0]  month;
	logic [7:0]  ptype;
	logic [7:0]  pkt [26];
	int          n_fail, n_compared;

	bld_link_if link (.clk_i(clk_i));
	bld_device i_bld_device (.clk_i(clk_i), .rst_n_i(rst_n_i), .rx_start_i(rx_start),
		.rx_fmt2_i(rx_fmt2), .rx_bit_i(rx_bit), .rx_bit_en_i(rx_bit_en),
		.rx_busy_o(rx_busy), .link(link));
	bld_host i_bld_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link), .busy_o(busy),
		.f1_valid_o(f1_v), .f2_valid_o(f2_v), .julian_day_number_o(jdn),
		.unified_date_time_o(unified_date_time), .offset_neg_o(ofs_neg), .offset_mag_o(ofs_mag),
		.label_channel_id_o(lci), .label_update_flag_o(label_update_flag), .sound_status_o(snd),
		.network_country_id_o(net), .programme_label_o(label), .label_day_o(day),
		.label_month_o(month), .label_hour_o(hour), .label_minute_o(minute),
		.programme_type_o(ptype));
	bld_link_sva i_bld_link_sva (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.pkt_ready(link.pkt_ready), .pkt_fmt2(link.pkt_fmt2), .rd_req(link.rd_req),
		.rd_addr(link.rd_addr), .rd_ack(link.rd_ack), .rd_data(link.rd_data));

	// 50 MHz
	always #10 clk_i = ~clk_i;

	// message nibble of a protected byte, first message bit lowest
	function automatic logic [3:0] nib(input logic [7:0] b);
		nib = {b[7], b[5], b[3], b[1]};
	endfunction : nib
	// undo the plus one put on each digit before sending
	function automatic logic [3:0] fx(input logic [3:0] d);
		fx = d - 4'h1;
	endfunction : fx

	task automatic chk(input logic [23:0] s, input logic [23:0] e, input string m);
		n_compared++;
		if (s !== e) begin
			n_fail++;
			$display("BAD t=%0t %s: seen %h expected %h", $time, m, s, e);
		end
	endtask : chk

	task automatic print_verdict;
		$display("compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict

	// every byte the host takes must be the byte that went on air
	always @(negedge clk_i) begin
		if (rst_n_i && link.rd_ack === 1'b1 && link.rd_addr <= F2_LAST)
			chk(link.rd_data, pkt[link.rd_addr], "byte");
	end

	// start, then bits lsb first with random gaps, often back to back
	task automatic send(input logic fmt2, input int nbits);
		int i;
		i = 0;
		rx_start = 1'b1;
		rx_fmt2 = fmt2;
		@(negedge clk_i);
		rx_start = 1'b0;
		chk(rx_busy, 1, "rx busy");
		while (i < nbits) begin
			if ($urandom_range(2, 0) != 0) begin
				rx_bit = pkt[i / 8][i % 8];
				rx_bit_en = 1'b1;
				i++;
			end else begin
				rx_bit_en = 1'b0;
				rx_bit = 1'($urandom);
			end
			@(negedge clk_i);
		end
		rx_bit_en = 1'b0;
		chk(rx_busy, nbits < 208, "rx busy at end");
	endtask : send

	// wait for the field pulse, then compare against fields built here
	task automatic verify(input logic fmt2);
		logic [3:0]  n [26];
		logic [19:0] e_lbl;
		int          k;
		k = 0;
		while (f1_v !== 1'b1 && f2_v !== 1'b1 && k < 800) begin
			@(negedge clk_i);
			k++;
		end
		chk({f1_v, f2_v}, {~fmt2, fmt2}, "format pulse");
		chk(busy, 0, "busy");
		for (int i = 0; i < 26; i++)
			n[i] = nib(pkt[i]);
		e_lbl = {n[21][1:0], n[20], n[19], n[18], n[17], n[16][3:2]};
		if (!fmt2) begin
			chk(jdn, {fx(pkt[16][3:0]), fx(pkt[17][7:4]), fx(pkt[17][3:0]),
				fx(pkt[18][7:4]), fx(pkt[18][3:0])}, "day number");
			chk(unified_date_time, {fx(pkt[19][7:4]), fx(pkt[19][3:0]), fx(pkt[20][7:4]),
				fx(pkt[20][3:0]), fx(pkt[21][7:4]), fx(pkt[21][3:0])}, "time");
			chk({ofs_neg, ofs_mag}, pkt[15][6:0], "offset");
		end else begin
			chk({lci, label_update_flag}, {n[13][1:0], n[13][2]}, "label ctl");
			chk(snd, n[14][1:0], "sound");
			chk(net, {n[23], n[22][3:2], n[16][1:0], n[22][1:0], n[21][3:2], n[15]}, "net");
			chk(label, e_lbl, "label");
			chk({minute, hour, month, day}, e_lbl, "label parts");
			chk(ptype, {n[25], n[24]}, "type");
		end
	endtask : verify

	// corners first: all zero digits, all ones, restart mid packet, reset mid run
	initial begin
		clk_i = 1'b0;
		rst_n_i = 1'b0;
		rx_start = 1'b0;
		rx_fmt2 = 1'b0;
		rx_bit = 1'b0;
		rx_bit_en = 1'b0;
		n_fail = 0;
		n_compared = 0;
		void'($urandom(85));
		repeat (16) @(negedge clk_i);
		chk(jdn, 0, "reset");
		rst_n_i = 1'b1;
		for (int t = 0; t < 12; t++) begin
			for (int b = 0; b < 26; b++)
				pkt[b] = (t == 0) ? 8'h00 : (t == 1) ? 8'hFF : 8'($urandom);
			if (t == 2) begin
				send(1'b1, 40);
				for (int b = 0; b < 26; b++)
					pkt[b] = 8'($urandom);
			end
			if (t == 6) begin
				rst_n_i = 1'b0;
				repeat (2) @(negedge clk_i);
				chk(unified_date_time, 0, "reset time");
				chk(net, 0, "reset net");
				rst_n_i = 1'b1;
			end
			send(t[0], 208);
			verify(t[0]);
			$display("test %0d done", t);
		end
		print_verdict();
	end

	// cut a hang short well past the expected run length
	initial begin
		repeat (30000) @(posedge clk_i);
		n_fail++;
		$display("BAD t=%0t watchdog expired", $time);
		print_verdict();
	end
endmodule : tb_broadcast_label_field_decoder
`default_nettype wire
